// ==== spbtr_core.sv ====
// Purpose: Serial port core with fractional baud generator, tx and rx paths
// Assumes: Single 100 MHz clock; line and transfer clock pins synchronised here
// Notes:   Avalon-MM slave, one wait state on every access
`default_nettype none

module spbtr_core
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        rx_pin_in,
  output logic             tx_pin_out,
  output logic             tx_pin_oe_n_out,
  input  wire logic        transfer_clock_pin_in,
  output logic             transfer_clock_pin_out,
  output logic             transfer_clock_pin_oe_n_out
);
  // ------------------------------------------------------------------
  // Registers and pin synchronisers
  // ------------------------------------------------------------------
  logic [15:0] baud_reg;
  logic [5:0]  ctrl_reg;
  logic [5:0]  frame_reg;
  logic        tx_en_reg;
  logic        tx_hi_reg;
  logic [8:0]  txbuf_reg;
  logic        txbuf_full_reg;
  logic        txc_reg;
  logic [1:0]  rxs_reg;
  logic [1:0]  xcks_reg;
  logic        xck_prev_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // Both sync chains: only the second stage is read by logic
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rxs_reg  <= 2'h3;
      xcks_reg <= 2'h0;
    end
    else
    begin
      rxs_reg  <= {rxs_reg[0], rx_pin_in};
      xcks_reg <= {xcks_reg[0], transfer_clock_pin_in};
    end
  end
  wire rx_s  = rxs_reg[1];
  wire xck_s = xcks_reg[1];

  wire       rx_on   = ctrl_reg[spbtr_pkg::CTRL_RXEN];
  wire       sync_m  = ctrl_reg[spbtr_pkg::CTRL_SYNC];
  wire       slave_m = sync_m & ctrl_reg[spbtr_pkg::CTRL_SLAVE];
  wire [1:0] rxmode  = ctrl_reg[spbtr_pkg::CTRL_RXMODE +: 2];
  wire [2:0] chsz    = frame_reg[spbtr_pkg::FRM_CHSZ +: 3];
  wire       nine    = (chsz == spbtr_pkg::CHSZ_9L) | (chsz == spbtr_pkg::CHSZ_9H);
  wire [3:0] nbits   = nine ? 4'h9 : (4'h5 + {1'b0, chsz});

  // ------------------------------------------------------------------
  // Fractional baud generator
  // ------------------------------------------------------------------
  // Samples per bit by mode
  wire [4:0] spb = sync_m ? spbtr_pkg::SPB_SYNC :
                   (rxmode == 2'h1) ? spbtr_pkg::SPB_DOUBLE : spbtr_pkg::SPB_NORMAL;
  logic [9:0]  bcnt_reg;
  logic [5:0]  facc_reg;
  logic        tick_reg;
  // Fraction accumulator carry adds one clock to some periods
  wire [6:0]  facc_sum = {1'b0, facc_reg} + {1'b0, baud_reg[5:0]};
  wire        fextra   = ~sync_m & facc_sum[6];
  wire [9:0]  bint     = baud_reg[15:spbtr_pkg::FRAC_BITS];
  // Async: tick every BAUD/64 clocks at S ticks/bit; sync: period S*int
  wire [9:0]  bload    = (bint == 10'h000) ? 10'h000 : bint - 10'h001;
  // Tick is the sample clock; extra cycle when fraction overflows
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bcnt_reg <= 10'h000;
      facc_reg <= 6'h00;
      tick_reg <= 1'b0;
    end
    else if (bcnt_reg == 10'h000)
    begin
      facc_reg <= sync_m ? 6'h00 : facc_sum[5:0];
      bcnt_reg <= bload + {9'h000, fextra};
      tick_reg <= 1'b1;
    end
    else
    begin
      bcnt_reg <= bcnt_reg - 10'h001;
      tick_reg <= 1'b0;
    end
  end

  // Master: sync clock toggles at half bit; slave: external edges
  logic [4:0] sph_reg;
  logic       xck_out_reg;
  wire        xck_rise = xck_s & ~xck_prev_reg;
  wire        xck_fall = ~xck_s & xck_prev_reg;
  wire        sph_wrap = tick_reg & (sph_reg == spb - 5'h01);
  // Bit strobes: shift on start-of-bit edge, sample on opposite edge
  wire        m_rise   = sync_m & ~slave_m & sph_wrap;
  wire        m_fall   = sync_m & ~slave_m & tick_reg & (sph_reg == 5'h00);
  wire        sh_en    = slave_m ? xck_rise : sync_m ? m_rise : sph_wrap;
  wire        smp_en   = slave_m ? xck_fall : m_fall;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sph_reg      <= 5'h00;
      xck_out_reg  <= 1'b0;
      xck_prev_reg <= 1'b0;
    end
    else
    begin
      xck_prev_reg <= xck_s;
      if (tick_reg)
        sph_reg <= sph_wrap ? 5'h00 : sph_reg + 5'h01;
      if (m_rise)
        xck_out_reg <= 1'b1;
      else if (m_fall)
        xck_out_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  logic [11:0] tsh_reg;
  logic [3:0]  tcnt_reg;
  logic        tbusy_reg;
  logic        txo_reg;
  // Parity over the data bits actually sent
  function automatic logic par9(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        p = p ^ d[i];
    return p;
  endfunction
  wire        paren  = frame_reg[spbtr_pkg::FRM_PAREN];
  wire        podd   = frame_reg[spbtr_pkg::FRM_PODD];
  wire        stop2  = frame_reg[spbtr_pkg::FRM_STOP2];
  wire [3:0]  tlen   = nbits + {3'h0, paren} + {3'h0, stop2} + 4'h1;
  // Data beyond the character width masked off before parity and shift
  wire [8:0]  tmask  = 9'h1FF >> (4'h9 - nbits);
  wire [8:0]  tdat   = txbuf_reg & tmask;
  // Ones above the character, so that the stop bits never shift out low
  wire [11:0] tframe = {3'h7, tdat | ~tmask};
  wire        tpar   = par9(tdat, nbits, podd);
  wire [11:0] tload  = paren ? ((tframe & ~(12'h001 << nbits)) | ({11'h000, tpar} << nbits))
                             : tframe;
  // Last stop bit ends here; a waiting character starts straight after it
  wire        tlast    = tbusy_reg & sh_en & (tcnt_reg == 4'h0);
  wire        tload_go = tx_en_reg & txbuf_full_reg & (~tbusy_reg | tlast) & sh_en;
  wire        wr_txl   = avs_write_in & ~ack_reg & (avs_address_in == spbtr_pkg::OFS_TX_LOW);
  wire        wr_txh   = avs_write_in & ~ack_reg & (avs_address_in == spbtr_pkg::OFS_TX_HIGH);
  // Start bit first, then data, parity, stops, all LSB first
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tsh_reg   <= 12'hFFF;
      tcnt_reg  <= 4'h0;
      tbusy_reg <= 1'b0;
      txo_reg   <= 1'b1;
    end
    else if (tload_go)
    begin
      txo_reg   <= 1'b0;
      tsh_reg   <= tload;
      tcnt_reg  <= tlen;
      tbusy_reg <= 1'b1;
    end
    else if (tbusy_reg & sh_en)
    begin
      txo_reg   <= tsh_reg[0];
      tsh_reg   <= {1'b1, tsh_reg[11:1]};
      tcnt_reg  <= tcnt_reg - 4'h1;
      tbusy_reg <= (tcnt_reg != 4'h0);
    end
  end
  // Single-entry transmit buffer; new write while full is dropped
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      txbuf_reg      <= 9'h000;
      txbuf_full_reg <= 1'b0;
      tx_hi_reg      <= 1'b0;
      txc_reg        <= 1'b0;
    end
    else
    begin
      if (wr_txh & avs_byteenable_in[0])
        tx_hi_reg <= avs_writedata_in[0];
      if (tload_go)
        txbuf_full_reg <= 1'b0;
      else if (wr_txl & avs_byteenable_in[0] & ~txbuf_full_reg)
      begin
        txbuf_reg      <= {tx_hi_reg, avs_writedata_in[7:0]};
        txbuf_full_reg <= 1'b1;
      end
      // Completion set beats the write-one clear
      if (tlast & ~txbuf_full_reg)
        txc_reg <= 1'b1;
      else if (avs_write_in & ~ack_reg & (avs_address_in == spbtr_pkg::OFS_STATUS)
               & avs_writedata_in[spbtr_pkg::ST_TXC])
        txc_reg <= 1'b0;
    end
  end
  // Disable only lands once nothing is left to send
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      tx_en_reg <= 1'b0;
    else if (ctrl_reg[spbtr_pkg::CTRL_TXEN])
      tx_en_reg <= 1'b1;
    else if (~tbusy_reg & ~txbuf_full_reg)
      tx_en_reg <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  logic [10:0] rsh_reg;
  logic [3:0]  rcnt_reg;
  logic        rbusy_reg;
  logic [4:0]  rph_reg;
  spbtr_pkg::spbtr_rxent_t rbuf_reg [2];
  logic [1:0]  rcount_reg;
  // Async sample point is mid bit; sync samples on the sample edge
  wire [4:0] rhalf = {1'b0, spb[4:1]};
  wire       asamp = ~sync_m & tick_reg & (rph_reg == rhalf - 5'h01);
  wire       rsamp = sync_m ? smp_en : asamp;
  wire [3:0] rlen  = nbits + {3'h0, paren} + 4'h1;                    // One stop only
  wire       rdone = rbusy_reg & rsamp & (rcnt_reg == 4'h0);
  // Data sits right-aligned under the parity bit when the stop bit is sampled
  wire [10:0] ralign = rsh_reg >> (4'hB - rlen + 4'h1);
  wire [8:0] rdat  = ralign[8:0] & tmask;
  wire       rpbit = ralign[nbits];
  wire       rperr = paren & (par9(rdat, nbits, podd) != rpbit);
  wire       rd_lo = avs_read_in & ~ack_reg & (avs_address_in == spbtr_pkg::OFS_RX_LOW);
  wire       rd_hi = avs_read_in & ~ack_reg & (avs_address_in == spbtr_pkg::OFS_RX_HIGH);
  wire       pop   = (rcount_reg != 2'h0) &
                     ((chsz == spbtr_pkg::CHSZ_9L) ? rd_hi : rd_lo);
  wire spbtr_pkg::spbtr_rxent_t rnew = '{data: rdat, frame_error_flag: ~rx_s, parity_error_flag: rperr,
                                         ovf: 1'b0};
  // Frame shift: start detect, mid-bit sampling, stop check
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rsh_reg   <= 11'h000;
      rcnt_reg  <= 4'h0;
      rbusy_reg <= 1'b0;
      rph_reg   <= 5'h00;
    end
    else if (~rx_on)
    begin
      rbusy_reg <= 1'b0;
      rph_reg   <= 5'h00;
    end
    else if (~rbusy_reg)
    begin
      rph_reg <= 5'h00;
      // Async start bit confirmed by mid-bit sample further down
      if (~rx_s & (~sync_m | smp_en))
      begin
        rbusy_reg <= 1'b1;
        rcnt_reg  <= sync_m ? rlen - 4'h1 : rlen;
      end
    end
    else
    begin
      if (tick_reg & ~sync_m)
        rph_reg <= (rph_reg == spb - 5'h01) ? 5'h00 : rph_reg + 5'h01;
      if (rsamp)
      begin
        // False start bit: line high at start mid-point aborts
        if (~sync_m & (rcnt_reg == rlen) & rx_s)
          rbusy_reg <= 1'b0;
        else
        begin
          if (rcnt_reg != rlen)
            rsh_reg <= {rx_s, rsh_reg[10:1]};
          rcnt_reg  <= rcnt_reg - 4'h1;
          rbusy_reg <= (rcnt_reg != 4'h0);
        end
      end
    end
  end
  // Two-entry receive buffer; when full the newer frame overwrites the last
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rbuf_reg[0]  <= '0;
      rbuf_reg[1]  <= '0;
      rcount_reg   <= 2'h0;
    end
    else if (~rx_on)
    begin
      rcount_reg   <= 2'h0;
    end
    else
    begin
      if (pop)
        rbuf_reg[0] <= rbuf_reg[1];
      if (rdone)
      begin
        // Newest character lands behind whatever remains after a pop
        if (rcount_reg == 2'h2 & ~pop)
        begin
          rbuf_reg[1] <= '{data: rnew.data, frame_error_flag: rnew.frame_error_flag, parity_error_flag: rnew.parity_error_flag,
                           ovf: 1'b1};
        end
        else
        begin
          rbuf_reg[(rcount_reg - {1'b0, pop}) == 2'h0 ? 0 : 1] <= rnew;
          rcount_reg <= rcount_reg + 2'h1 - {1'b0, pop};
        end
      end
      else if (pop)
        rcount_reg <= rcount_reg - 2'h1;
    end
  end
  wire rxc = (rcount_reg != 2'h0);

  // ------------------------------------------------------------------
  // Avalon-MM slave: one wait state, unmapped reads return zero
  // ------------------------------------------------------------------
  wire [31:0] status_w = {24'h0, rxc, txc_reg, ~txbuf_full_reg, 5'h00};
  wire [31:0] rd_mux =
    (avs_address_in == spbtr_pkg::OFS_RX_LOW)  ? {24'h0, rbuf_reg[0].data[7:0]} :
    (avs_address_in == spbtr_pkg::OFS_RX_HIGH) ? {24'h0, rxc, 3'h0, rbuf_reg[0].frame_error_flag,
                                                  rbuf_reg[0].ovf, rbuf_reg[0].parity_error_flag,
                                                  rbuf_reg[0].data[8]} :
    (avs_address_in == spbtr_pkg::OFS_STATUS)  ? status_w :
    (avs_address_in == spbtr_pkg::OFS_CTRL)    ? {26'h0, ctrl_reg} :
    (avs_address_in == spbtr_pkg::OFS_FRAME)   ? {26'h0, frame_reg} :
    (avs_address_in == spbtr_pkg::OFS_BAUD)    ? {16'h0, baud_reg} : 32'h0;
  wire wr_go = avs_write_in & ~ack_reg;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ack_reg   <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      rdata_reg <= 32'h0;
      ctrl_reg  <= spbtr_pkg::CTRL_RST;
      frame_reg <= spbtr_pkg::FRAME_RST;
      baud_reg  <= spbtr_pkg::BAUD_RST;
    end
    else
    begin
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
      // Registered wait: high while idle, low for the one answering cycle
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_reg);
      if (avs_read_in & ~ack_reg)
        rdata_reg <= rd_mux;
      if (wr_go & avs_byteenable_in[0] & (avs_address_in == spbtr_pkg::OFS_CTRL))
        ctrl_reg <= avs_writedata_in[5:0];
      if (wr_go & avs_byteenable_in[0] & (avs_address_in == spbtr_pkg::OFS_FRAME))
        frame_reg <= avs_writedata_in[5:0];
      if (wr_go & (avs_address_in == spbtr_pkg::OFS_BAUD))
      begin
        if (avs_byteenable_in[0])
          baud_reg[7:0] <= avs_writedata_in[7:0];
        if (avs_byteenable_in[1])
          baud_reg[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all registered
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_pin_out                  <= 1'b1;
      tx_pin_oe_n_out             <= 1'b1;
      transfer_clock_pin_out      <= 1'b0;
      transfer_clock_pin_oe_n_out <= 1'b1;
    end
    else
    begin
      tx_pin_out                  <= txo_reg;
      tx_pin_oe_n_out             <= ~tx_en_reg;
      transfer_clock_pin_out      <= xck_out_reg;
      transfer_clock_pin_oe_n_out <= ~(sync_m & ~slave_m);
    end
  end
  assign avs_readdata_out    = rdata_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  txc_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (tlast & ~txbuf_full_reg) |=> txc_reg) else $error("complete flag missed");
  tx_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(tx_en_reg) |-> ($past(~tbusy_reg) & $past(~txbuf_full_reg)))
    else $error("tx disabled early");
  rx_flush_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ~rx_on |=> (rcount_reg == 2'h0) & ~rbusy_reg) else $error("rx not flushed");
  rx_cap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rcount_reg != 2'h3) else $error("rx buffer over two");
  pin_rel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ~tx_en_reg |=> tx_pin_oe_n_out) else $error("pin not released");
  spb_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sync_m |-> (spb == 5'h02)) else $error("sync samples wrong");
  sequence s_load; tload_go; endsequence
  tx_start_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_load |=> ~txo_reg ##1 ~txo_reg) else $error("start bit missing");
  tx_buf_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tload_go |=> ~txbuf_full_reg) else $error("buffer not moved");
endmodule // spbtr_core

`default_nettype wire

// ==== spbtr_pkg.sv ====
// Purpose: Shared constants and types for the serial port baud/tx/rx core
// Assumes: 100 MHz peripheral clock, Avalon-MM register access
// Notes:   Register offsets are byte addresses of 32-bit words
//
// How it works
// - Rate divider is a divisor with six fractional LSBs; rate = 64*fclk/(S*div).
// - Synchronous mode uses only divider bits 15:6; bits 5:0 written zero.
// - Samples per bit: 16 normal, 8 double speed, 2 synchronous.
// - Internal rate generator clocks shifting unless the transfer clock pin does.
// - Transmit data write fills buffer; it moves to empty shifter, then is sent.
// - Last bit out with empty buffer sets transmit-complete flag.
// - Surplus upper transmit bits ignored; ninth bit written before low byte.
// - Transmitter disable waits until shifter and buffer are both empty.
// - Disabled transmitter releases the pin and forces its direction to input.
// - Receiver starts on valid start bit, shifts to first stop, ignores second.
// - First stop bit moves frame into receive buffer and sets receive-complete.
// - Unused received upper bits read zero; nine-bit high byte read first, low byte first in low-first size.
// - Frame, overflow and parity flags stored with their character, read high byte.
// - Parity error set when computed data parity mismatches received parity bit.
// - Overflow flag marks data lost because buffer was full at frame end.
// - Normally reading the low receive byte advances the receive buffer.
// - In nine-bit low-first size, reading the high byte advances instead.
// - Receiver disable is immediate, flushing buffer and dropping ongoing frame.
// - Synchronous mode supports both master and slave transfer clock roles.
// - Four async receive modes: one double speed, three normal speed.
// - Frame: low start, 5-9 data, optional parity, 1-2 high stops; idle high.
// - One transmit buffer before shifter; two-entry receive buffer after shifter.
`default_nettype none

package spbtr_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_RX_LOW  = 5'h00;
  localparam logic [4:0] OFS_RX_HIGH = 5'h04;
  localparam logic [4:0] OFS_TX_LOW  = 5'h08;
  localparam logic [4:0] OFS_TX_HIGH = 5'h0C;
  localparam logic [4:0] OFS_STATUS  = 5'h10;
  localparam logic [4:0] OFS_CTRL    = 5'h14;
  localparam logic [4:0] OFS_FRAME   = 5'h18;
  localparam logic [4:0] OFS_BAUD    = 5'h1C;
  // Control field positions
  localparam int CTRL_RXEN   = 0;
  localparam int CTRL_TXEN   = 1;
  localparam int CTRL_RXMODE = 2;  // 2 bits: 0 normal, 1 double, 2..3 normal variants
  localparam int CTRL_SYNC   = 4;
  localparam int CTRL_SLAVE  = 5;
  // Frame field positions
  localparam int FRM_CHSZ    = 0;  // 3 bits
  localparam int FRM_PAREN   = 3;
  localparam int FRM_PODD    = 4;
  localparam int FRM_STOP2   = 5;
  // Character size encodings
  localparam logic [2:0] CHSZ_5   = 3'h0;
  localparam logic [2:0] CHSZ_9L  = 3'h6;
  localparam logic [2:0] CHSZ_9H  = 3'h7;
  // Status bit positions
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_DRE = 5;
  // Reset values
  localparam logic [15:0] BAUD_RST  = 16'h0040;
  localparam logic [5:0]  CTRL_RST  = 6'h00;
  localparam logic [5:0]  FRAME_RST = 6'h03;
  // Samples per bit
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SPB_SYNC   = 5'h02;
  localparam int FRAC_BITS = 6;
  localparam logic [7:0] RX_HALF_NORMAL = 8'h08;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_error_flag;
    logic       parity_error_flag;
    logic       ovf;
  } spbtr_rxent_t;
endpackage : spbtr_pkg

`default_nettype wire

// ==== spbtr_remote.sv ====
// Purpose: Remote serial device facing the core on the line
// Assumes: Async frames, eight data bits seen by its receiver
// Notes:   Behavioural; line idles high through a pull-up
`default_nettype none
module spbtr_remote #(parameter int BIT_CLKS = 64)
(
  input  wire logic       clk_in,
  input  wire logic       line_in,
  output logic            line_out,
  output logic [7:0]      got_out,
  output logic            got_stb_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    line_out = 1'b1;
    got_stb_out = 1'b0;
    got_out = 8'h00;
  end
  // Start low, n bits LSB first, stop high; caller enters just after an edge
  task automatic send(input logic [8:0] v, input int n);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      line_out <= v[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_in);
  endtask
  // Mid-bit sampling after the start edge, then a one-cycle strobe
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_in);
      got_out[i] <= line_in;
    end
    repeat (BIT_CLKS) @(posedge clk_in);
    got_stb_out <= 1'b1;
    @(posedge clk_in);
    got_stb_out <= 1'b0;
  end
endmodule // spbtr_remote
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the serial core
// Assumes: BAUD 0x100 gives 64 clocks per bit in normal mode
// Notes:   Transmit results checked through a queue of expected bytes
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, resetn_in = 0, rd = 0, wr = 0, wait_o, oe_n, txp, rxl, stb;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdat, r;
  logic [7:0] got, b[3];
  logic [7:0] txq[$];
  int fails = 0, checks = 0, cyc = 0, seed = 3087;
  always #5 clk_in = ~clk_in;
  spbtr_core spbtr_core_inst (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_o), .rx_pin_in(rxl),
    .tx_pin_out(txp), .tx_pin_oe_n_out(oe_n), .transfer_clock_pin_in(1'b0),
    .transfer_clock_pin_out(), .transfer_clock_pin_oe_n_out());
  // Released pin floats to the pull-up level
  spbtr_remote spbtr_remote_inst (.clk_in(clk_in), .line_in(oe_n ? 1'b1 : txp),
    .line_out(rxl), .got_out(got), .got_stb_out(stb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_in); while (wait_o !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rxchk(input logic [7:0] hi, input logic [7:0] lo);
    bus(0, spbtr_pkg::OFS_RX_HIGH, 0);
    check(r, {24'h0, hi});
    bus(0, spbtr_pkg::OFS_RX_LOW, 0);
    check(r, {24'h0, lo});
  endtask
  // Each byte seen on the line takes the oldest expected note
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc > 40000)
    begin
      fails++;
      test_done();
    end
    if (stb)
      check(got, txq.size() ? txq.pop_front() : 8'hXX);
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(1, spbtr_pkg::OFS_BAUD, 32'h0000_0100);
    bus(1, spbtr_pkg::OFS_CTRL, 32'h0000_0003);
    // Back-to-back sends; the last one in five-bit size sees stop and idle on top
    for (int i = 0; i < 4; i++)
    begin
      do bus(0, spbtr_pkg::OFS_STATUS, 0); while (r[spbtr_pkg::ST_DRE] !== 1'b1);
      if (i == 3)
        bus(1, spbtr_pkg::OFS_FRAME, 32'h0);
      wd <= $random(seed);
      @(posedge clk_in);
      txq.push_back(i == 3 ? {3'h7, wd[4:0]} : wd[7:0]);
      bus(1, spbtr_pkg::OFS_TX_LOW, wd);
    end
    do bus(0, spbtr_pkg::OFS_STATUS, 0); while (r[spbtr_pkg::ST_TXC] !== 1'b1);
    // The remote strobes its eight-bit view two and a half bit times after the stop ends
    repeat (256) @(posedge clk_in);
    check(txq.size(), 0);
    bus(1, spbtr_pkg::OFS_STATUS, 32'h40);
    bus(0, spbtr_pkg::OFS_STATUS, 0);
    check(r[spbtr_pkg::ST_TXC], 0);
    // Five-bit receive reads zeros above the character
    b[0] = $random(seed);
    spbtr_remote_inst.send({4'h0, b[0][4:0]}, 5);
    repeat (8) @(posedge clk_in);
    rxchk(8'h80, {3'h0, b[0][4:0]});
    // Three frames unread: the third overwrites the newest entry with overflow
    bus(1, spbtr_pkg::OFS_FRAME, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      b[i] = $random(seed);
      spbtr_remote_inst.send({1'b0, b[i]}, 8);
    end
    repeat (8) @(posedge clk_in);
    rxchk(8'h80, b[0]);
    rxchk(8'h84, b[2]);
    // Even parity with a wrong parity bit on the wire
    bus(1, spbtr_pkg::OFS_FRAME, 32'hB);
    spbtr_remote_inst.send({~^b[1], b[1]}, 9);
    repeat (8) @(posedge clk_in);
    rxchk(8'h82, b[1]);
    // Nine bits low first: the high byte read pops the entry
    bus(1, spbtr_pkg::OFS_FRAME, 32'h6);
    spbtr_remote_inst.send({1'b1, b[0]}, 9);
    repeat (8) @(posedge clk_in);
    bus(0, spbtr_pkg::OFS_RX_LOW, 0);
    check(r, {24'h0, b[0]});
    bus(0, spbtr_pkg::OFS_RX_HIGH, 0);
    check(r, 32'h81);
    bus(0, spbtr_pkg::OFS_STATUS, 0);
    check(r[spbtr_pkg::ST_RXC], 0);
    // Receiver off flushes a held frame at once
    spbtr_remote_inst.send({^b[1], b[1]}, 9);
    bus(0, spbtr_pkg::OFS_STATUS, 0);
    check(r[spbtr_pkg::ST_RXC], 1);
    bus(1, spbtr_pkg::OFS_CTRL, 32'h2);
    bus(0, spbtr_pkg::OFS_STATUS, 0);
    check(r[spbtr_pkg::ST_RXC], 0);
    // Transmitter off waits for the frame, then lets the pin go
    txq.push_back(b[2]);
    bus(1, spbtr_pkg::OFS_TX_LOW, {24'h0, b[2]});
    bus(1, spbtr_pkg::OFS_CTRL, 32'h0);
    check(oe_n, 0);
    repeat (1000) @(posedge clk_in);
    check(oe_n, 1);
    check(txq.size(), 0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
